/* File: pkg/ldlp_pkg.sv */
// constants for the line diagnostic loopback and pattern block
package ldlp_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  // control register fields
  localparam int LOCAL_LOOP_BIT = 0;
  localparam int ANALOG_LOOP_BIT = 1;
  localparam int REMOTE_LOOP_BIT = 2;
  localparam int ALL_ONES_BIT = 3;
  localparam int PAT_SEL_LOW_BIT = 4;
  localparam int PAT_SEL_HIGH_BIT = 5;
  localparam int JA_ENABLE_BIT = 6;
  localparam int E1_MODE_BIT = 7;
  localparam int EDGE_SEL_BIT = 8;
  localparam int UNIPOLAR_BIT = 9;
  localparam int CODERS_EN_BIT = 10;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  // status and interrupt clear register fields
  localparam int SYNC_STAT_BIT = 0;
  localparam int TRANSITION_BIT = 1;
  localparam int IRQ_CLR_BIT = 0;
  // synchronised pin vector positions
  localparam int PIN_HOST = 0;
  localparam int PIN_LL_HI = 1;
  localparam int PIN_LL_MID = 2;
  localparam int PIN_RL_HI = 3;
  localparam int PIN_AO_HI = 4;
  localparam int PIN_AO_MID = 5;
  localparam int PIN_JA_EN = 6;
  localparam int PIN_TX_CLK = 7;
  localparam int PIN_TX_POS = 8;
  localparam int PIN_TX_NEG = 9;
  localparam int PIN_RX_CLK = 10;
  localparam int PIN_RX_POS = 11;
  localparam int PIN_RX_NEG = 12;
  localparam int PIN_LER = 13;
  localparam int PIN_VIOL = 14;
  localparam int PIN_LOS = 15;
  localparam int PIN_RX_VIOL = 16;
  localparam int PIN_W = 17;
  // pattern generator and detector figures
  localparam int PRBS_W = 20;
  localparam logic [19:0] PRBS_SEED = 20'h00001;
  localparam logic [4:0] JAM_ZEROS = 5'h0e;
  localparam logic [6:0] SYNC_WIN_LAST = 7'h7f;
  localparam logic [7:0] SYNC_GAIN_LIMIT = 8'h04;
  localparam logic [7:0] SYNC_LOSS_LIMIT = 8'h04;
  // master clock fallback timing, in core clock cycles
  localparam int TXCLK_LOSS_CYCLES = 64;
  localparam int MCLK_HALF_CYCLES = 65;
endpackage

/* File: src/ldlp_core.sv */
// line diagnostic loopback, all-ones, test pattern generator and detector
// Notes on behaviour
// [R1] local loop: receiver inhibited, transmit to receive
// [R2] in local loop attenuator select only enables
// [R3] local loop still transmits data or ones
// [R4] other party requests local loop by pin/bit
// [R5] analog loop feeds transmit back to receiver
// [R6] analog loop from midrange pin or bit
// [R7] analog loop overrides all other loops
// [R8] remote loop retransmits receive data, rx clock
// [R9] other party requests remote loop by pin/bit
// [R10] local plus remote gives dual loop
// [R11] all ones ignores rails, master clock fallback
// [R12] remote loop suppresses all ones
// [R13] other party starts all ones by pin/bit
// [R14] t1 pattern 2^20-1, one after 14 zeros
// [R15] e1 pattern 2^15-1, output inverted
// [R16] pattern clocked by tx clock, else master
// [R17] error insert edge, deferred past jammed bit
// [R18] violation insert edge puts bipolar violation
// [R19] other party selects pattern by pin/bits
// [R20] sync when under four errors per 128
// [R21] bit error pulses detect output half cycle
// [R22] no sync or no signal holds output high
// [R23] interrupt on sync change, status and transition; interrupt raised only under host control
// [R24] mode pin chooses host or pin control
// [R25] write one clears, one held masks interrupt
`timescale 1ns/1ps
`default_nettype none
module ldlp_core #(
  parameter int LOSS_CYCLES = ldlp_pkg::TXCLK_LOSS_CYCLES,
  parameter int MCLK_HALF = ldlp_pkg::MCLK_HALF_CYCLES
) (
  input wire logic core_clk, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [16:0] pins_in, // asynchronous pins, see package positions
  output logic line_tx_pos, // positive rail towards line driver
  output logic line_tx_neg, // negative rail towards line driver
  output logic line_tx_clk, // clock towards line driver
  output logic rx_out_pos, // receive positive rail output
  output logic rx_out_neg, // receive negative rail output
  output logic rx_out_clk, // receive clock output
  output logic receiver_inhibit, // local loop, receiver off
  output logic analog_loop_en, // transmit outputs into receiver
  output logic ja_in_loop, // attenuator active in local loop path
  output logic pattern_detect_out_n, // pattern detect, active low
  output logic bipolar_violation_out, // violation report
  output logic pattern_irq // sync change interrupt under host control only, active high
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [16:0] pin_s1_r;
  logic [16:0] pin_s2_r;
  logic [16:0] pin_d_r;
  // two flops before any logic; third stage only for edge finding
  always_ff @(posedge core_clk) begin
    pin_s1_r <= pins_in;
    pin_s2_r <= pin_s1_r;
    pin_d_r <= pin_s2_r;
  end

  logic tx_rise, rx_rise, rx_fall, ler_rise, viol_rise;
  assign tx_rise = pin_s2_r[ldlp_pkg::PIN_TX_CLK] & ~pin_d_r[ldlp_pkg::PIN_TX_CLK];
  assign rx_rise = pin_s2_r[ldlp_pkg::PIN_RX_CLK] & ~pin_d_r[ldlp_pkg::PIN_RX_CLK];
  assign rx_fall = ~pin_s2_r[ldlp_pkg::PIN_RX_CLK] & pin_d_r[ldlp_pkg::PIN_RX_CLK];
  assign ler_rise = pin_s2_r[ldlp_pkg::PIN_LER] & ~pin_d_r[ldlp_pkg::PIN_LER];
  assign viol_rise = pin_s2_r[ldlp_pkg::PIN_VIOL] & ~pin_d_r[ldlp_pkg::PIN_VIOL];

  ////////////////////////////////////////////////////////////////////
  // apb registers
  logic [ldlp_pkg::CTRL_W-1:0] ctrl_r;
  logic irq_clr_r;
  logic sync_r;
  logic transition_r;
  logic setup, access_wr, clr_cmd;
  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pready & pwrite;
  assign clr_cmd = access_wr & (paddr == ldlp_pkg::IRQ_CLR_OFF) & pwdata[ldlp_pkg::IRQ_CLR_BIT];

  // no wait state: answer prepared in setup, ready in access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~(paddr == ldlp_pkg::CTRL_OFF || paddr == ldlp_pkg::IRQ_CLR_OFF ||
                   paddr == ldlp_pkg::STATUS_OFF);
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          ldlp_pkg::CTRL_OFF: prdata <= {21'h000000, ctrl_r};
          ldlp_pkg::IRQ_CLR_OFF: prdata <= {31'h00000000, irq_clr_r};
          ldlp_pkg::STATUS_OFF: prdata <= {30'h00000000, transition_r, sync_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control and clear registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= ldlp_pkg::CTRL_RST;
      irq_clr_r <= 1'b0;
    end else if (access_wr) begin
      if (paddr == ldlp_pkg::CTRL_OFF)
        ctrl_r <= pwdata[ldlp_pkg::CTRL_W-1:0];
      // [R25] held one masks
      if (paddr == ldlp_pkg::IRQ_CLR_OFF)
        irq_clr_r <= pwdata[ldlp_pkg::IRQ_CLR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode resolution
  logic host, ll_req, al_req, rl_req, ao_req, pat_mode, ja_en, e1, edge_sel;
  logic local_act, remote_act, ones_act;
  // [R24] host or pin control
  assign host = pin_s2_r[ldlp_pkg::PIN_HOST];
  // [R6] analog loop request
  assign al_req = host ? ctrl_r[ldlp_pkg::ANALOG_LOOP_BIT] : pin_s2_r[ldlp_pkg::PIN_LL_MID];
  assign ll_req = host ? ctrl_r[ldlp_pkg::LOCAL_LOOP_BIT] : pin_s2_r[ldlp_pkg::PIN_LL_HI];
  assign rl_req = host ? ctrl_r[ldlp_pkg::REMOTE_LOOP_BIT] : pin_s2_r[ldlp_pkg::PIN_RL_HI];
  assign ao_req = host ? ctrl_r[ldlp_pkg::ALL_ONES_BIT] : pin_s2_r[ldlp_pkg::PIN_AO_HI];
  // [R19] pattern selection
  assign pat_mode = host ? (~ctrl_r[ldlp_pkg::PAT_SEL_LOW_BIT] & ctrl_r[ldlp_pkg::PAT_SEL_HIGH_BIT])
                         : pin_s2_r[ldlp_pkg::PIN_AO_MID];
  assign ja_en = host ? ctrl_r[ldlp_pkg::JA_ENABLE_BIT] : pin_s2_r[ldlp_pkg::PIN_JA_EN];
  assign e1 = ctrl_r[ldlp_pkg::E1_MODE_BIT];
  // edge select exists only under host control
  assign edge_sel = host & ctrl_r[ldlp_pkg::EDGE_SEL_BIT];
  // [R7] analog loop wins
  assign local_act = ll_req & ~al_req;
  assign remote_act = rl_req & ~al_req;
  // [R12] remote inhibits ones
  assign ones_act = ao_req & ~remote_act;

  ////////////////////////////////////////////////////////////////////
  // transmit clock watchdog and master clock fallback
  logic [15:0] loss_cnt_r;
  logic [15:0] mdiv_r;
  logic mclk_r, tx_lost;
  assign tx_lost = (loss_cnt_r == 16'(LOSS_CYCLES));
  // loss count restarts on each tx clock rising edge
  always_ff @(posedge core_clk) begin
    if (rst)
      loss_cnt_r <= 16'h0000;
    else if (tx_rise)
      loss_cnt_r <= 16'h0000;
    else if (!tx_lost)
      loss_cnt_r <= loss_cnt_r + 16'h0001;
  end
  // free running divider stands in for the master clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mdiv_r <= 16'h0000;
      mclk_r <= 1'b0;
    end else if (mdiv_r == 16'(MCLK_HALF - 1)) begin
      mdiv_r <= 16'h0000;
      mclk_r <= ~mclk_r;
    end else begin
      mdiv_r <= mdiv_r + 16'h0001;
    end
  end
  logic mclk_tick, gen_tick, line_tick;
  assign mclk_tick = (mdiv_r == 16'(MCLK_HALF - 1)) & ~mclk_r;
  // [R16] tx clock else master
  assign gen_tick = tx_lost ? mclk_tick : tx_rise;
  // [R8] remote loop runs at rx clock
  assign line_tick = remote_act ? rx_rise : gen_tick;

  ////////////////////////////////////////////////////////////////////
  // pattern generator and transmit selection
  logic [19:0] lfsr_r;
  logic [4:0] gen_zrun_r;
  logic pol_r, err_pend_r, viol_pend_r;
  logic gen_fb, gen_jam, gen_bit, err_apply, tx_bit, mark_viol;
  assign gen_fb = e1 ? (lfsr_r[14] ^ lfsr_r[13]) : (lfsr_r[19] ^ lfsr_r[16]);
  // [R14] force a one after fourteen zeros
  assign gen_jam = ~e1 & ~gen_fb & (gen_zrun_r >= ldlp_pkg::JAM_ZEROS);
  // [R15] e1 output inverted
  assign gen_bit = e1 ? ~gen_fb : (gen_fb | gen_jam);
  // [R17] no insertion on jammed bit
  assign err_apply = err_pend_r & ~gen_jam & pat_mode & ~ones_act;
  assign tx_bit = gen_bit ^ err_apply;
  assign mark_viol = viol_pend_r & tx_bit & pat_mode & ~ones_act;

  // pending inserts: a new edge wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_pend_r <= 1'b0;
      viol_pend_r <= 1'b0;
    end else begin
      err_pend_r <= (err_pend_r & ~(gen_tick & err_apply)) | (ler_rise & pat_mode);
      viol_pend_r <= (viol_pend_r & ~(gen_tick & mark_viol)) | (viol_rise & pat_mode);
    end
  end

  // generator state advances on every generator tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lfsr_r <= ldlp_pkg::PRBS_SEED;
      gen_zrun_r <= 5'h00;
    end else if (gen_tick) begin
      lfsr_r <= {lfsr_r[18:0], gen_fb};
      gen_zrun_r <= gen_bit ? 5'h00 : gen_zrun_r + 5'h01;
    end
  end

  // line outputs; marks alternate unless a violation is due
  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
      pol_r <= 1'b0;
    end else if (line_tick) begin
      if (remote_act) begin
        // [R8] coders bypassed, rx data resent
        line_tx_pos <= pin_s2_r[ldlp_pkg::PIN_RX_POS];
        line_tx_neg <= pin_s2_r[ldlp_pkg::PIN_RX_NEG];
      end else if (ones_act) begin
        // [R11] continuous ones, rails ignored
        line_tx_pos <= ~pol_r;
        line_tx_neg <= pol_r;
        pol_r <= ~pol_r;
      end else if (pat_mode) begin
        // [R18] repeat polarity for violation
        line_tx_pos <= tx_bit & (mark_viol ? pol_r : ~pol_r);
        line_tx_neg <= tx_bit & (mark_viol ? ~pol_r : pol_r);
        if (tx_bit && !mark_viol)
          pol_r <= ~pol_r;
      end else begin
        // [R3] transmit inputs pass, local loop too
        line_tx_pos <= pin_s2_r[ldlp_pkg::PIN_TX_POS];
        line_tx_neg <= pin_s2_r[ldlp_pkg::PIN_TX_NEG];
      end
    end
  end

  // line clock follows whichever source times the data
  always_ff @(posedge core_clk) begin
    if (rst)
      line_tx_clk <= 1'b0;
    else if (remote_act)
      line_tx_clk <= pin_s2_r[ldlp_pkg::PIN_RX_CLK];
    else
      line_tx_clk <= tx_lost ? mclk_r : pin_s2_r[ldlp_pkg::PIN_TX_CLK];
  end

  ////////////////////////////////////////////////////////////////////
  // receive outputs and loop steering
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_out_pos <= 1'b0;
      rx_out_neg <= 1'b0;
      rx_out_clk <= 1'b0;
      receiver_inhibit <= 1'b0;
      analog_loop_en <= 1'b0;
      ja_in_loop <= 1'b0;
    end else begin
      // [R1] transmit side appears at receive
      // [R10] dual loop keeps both directions
      rx_out_pos <= local_act ? pin_s2_r[ldlp_pkg::PIN_TX_POS] : pin_s2_r[ldlp_pkg::PIN_RX_POS];
      rx_out_neg <= local_act ? pin_s2_r[ldlp_pkg::PIN_TX_NEG] : pin_s2_r[ldlp_pkg::PIN_RX_NEG];
      rx_out_clk <= local_act ? pin_s2_r[ldlp_pkg::PIN_TX_CLK] : pin_s2_r[ldlp_pkg::PIN_RX_CLK];
      receiver_inhibit <= local_act;
      // [R5] transmit outputs into receiver
      analog_loop_en <= al_req;
      // [R2] select only enables here
      ja_in_loop <= local_act & ja_en;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive pattern detector, self synchronising on rx clock
  logic [19:0] hist_r;
  logic [4:0] det_zrun_r;
  logic [6:0] win_r;
  logic [7:0] errs_r;
  logic rx_raw, rx_bit, det_pred, det_jam, det_err, win_end;
  assign rx_raw = pin_s2_r[ldlp_pkg::PIN_RX_POS] | pin_s2_r[ldlp_pkg::PIN_RX_NEG];
  assign rx_bit = e1 ? ~rx_raw : rx_raw;
  assign det_pred = e1 ? (hist_r[14] ^ hist_r[13]) : (hist_r[19] ^ hist_r[16]);
  assign det_jam = ~e1 & ~det_pred & (det_zrun_r >= ldlp_pkg::JAM_ZEROS);
  assign det_err = det_jam ? ~rx_bit : (rx_bit != det_pred);
  assign win_end = rx_rise & (win_r == ldlp_pkg::SYNC_WIN_LAST);

  // history takes the line bit; a jammed one is replaced by the prediction
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hist_r <= 20'h00000;
      det_zrun_r <= 5'h00;
    end else if (rx_rise && pat_mode) begin
      hist_r <= {hist_r[18:0], det_jam ? det_pred : rx_bit};
      det_zrun_r <= rx_raw ? 5'h00 : det_zrun_r + 5'h01;
    end
  end

  logic [7:0] errs_now;
  assign errs_now = errs_r + {7'h00, det_err};
  // [R20] 128 bit window error tally
  always_ff @(posedge core_clk) begin
    if (rst || !pat_mode) begin
      win_r <= 7'h00;
      errs_r <= 8'h00;
      sync_r <= 1'b0;
    end else if (rx_rise) begin
      win_r <= win_r + 7'h01;
      errs_r <= win_end ? 8'h00 : errs_now;
      if (win_end && !sync_r && errs_now < ldlp_pkg::SYNC_GAIN_LIMIT)
        sync_r <= 1'b1;
      // [R20] more than four drops sync
      else if (win_end && sync_r && errs_now > ldlp_pkg::SYNC_LOSS_LIMIT)
        sync_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // detect output: steady high unless in sync with no loss of signal, half cycle error pulses
  logic locked, pulse_r, late_err_r;
  assign locked = sync_r & ~pin_s2_r[ldlp_pkg::PIN_LOS];
  // [R21] pulse phase set by edge select
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulse_r <= 1'b0;
      late_err_r <= 1'b0;
    end else if (rx_rise) begin
      pulse_r <= ~edge_sel & locked & det_err;
      late_err_r <= edge_sel & locked & det_err;
    end else if (rx_fall) begin
      pulse_r <= late_err_r;
      late_err_r <= 1'b0;
    end
  end
  // [R22] no lock holds output high
  always_ff @(posedge core_clk) begin
    if (rst)
      pattern_detect_out_n <= 1'b1;
    else
      pattern_detect_out_n <= ~locked | pulse_r;
  end
  // violation report only while out of lock, if coding allows it
  always_ff @(posedge core_clk) begin
    if (rst)
      bipolar_violation_out <= 1'b0;
    else
      bipolar_violation_out <= ~locked & pin_s2_r[ldlp_pkg::PIN_RX_VIOL] &
                               (ctrl_r[ldlp_pkg::UNIPOLAR_BIT] | ctrl_r[ldlp_pkg::CODERS_EN_BIT]);
  end

  ////////////////////////////////////////////////////////////////////
  // sync transition flag and interrupt
  logic sync_d_r;
  // [R23] change sets, set beats clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_d_r <= 1'b0;
      transition_r <= 1'b0;
      pattern_irq <= 1'b0;
    end else begin
      sync_d_r <= sync_r;
      transition_r <= (sync_r != sync_d_r) | (transition_r & ~clr_cmd);
      pattern_irq <= host & transition_r & ~irq_clr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_analog_prio;
    al_req && ll_req |=> analog_loop_en && !receiver_inhibit;
  endproperty
  a_analog_prio: assert property (p_analog_prio) else $error("analog loop did not win"); // [R7]

  property p_local_clk;
    local_act |=> receiver_inhibit && rx_out_clk == $past(pin_s2_r[ldlp_pkg::PIN_TX_CLK]);
  endproperty
  a_local_clk: assert property (p_local_clk) else $error("local loop clock wrong"); // [R1]

  property p_ja_loop;
    local_act |=> ja_in_loop == $past(ja_en);
  endproperty
  a_ja_loop: assert property (p_ja_loop) else $error("attenuator enable wrong"); // [R2]

  property p_remote_data;
    remote_act && rx_rise && ao_req |=>
      line_tx_pos == $past(pin_s2_r[ldlp_pkg::PIN_RX_POS]) &&
      line_tx_neg == $past(pin_s2_r[ldlp_pkg::PIN_RX_NEG]);
  endproperty
  a_remote_data: assert property (p_remote_data) else $error("remote loop data wrong"); // [R12]

  property p_all_ones;
    ones_act && line_tick |=> line_tx_pos != line_tx_neg;
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("all ones lost a mark"); // [R11]

  property p_jam;
    pat_mode && !ones_act && !remote_act && gen_tick && gen_jam |=> line_tx_pos || line_tx_neg;
  endproperty
  a_jam: assert property (p_jam) else $error("jammed one missing"); // [R14]

  sequence s_unlocked2;
    !locked ##1 !locked;
  endsequence
  property p_detect_high;
    s_unlocked2 |-> pattern_detect_out_n;
  endproperty
  a_detect_high: assert property (p_detect_high) else $error("detect low without lock"); // [R22]

  sequence s_window_bad;
    win_end && sync_r && errs_now > ldlp_pkg::SYNC_LOSS_LIMIT;
  endsequence
  property p_sync_drop;
    s_window_bad |=> !sync_r ##1 transition_r;
  endproperty
  a_sync_drop: assert property (p_sync_drop) else $error("sync not dropped"); // [R23]

  property p_irq;
    host && transition_r && !irq_clr_r |=> pattern_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // [R23]

  property p_clear;
    clr_cmd && sync_r == sync_d_r |=> !transition_r ##1 !pattern_irq;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear"); // [R25]
endmodule
`default_nettype wire

/* File: tb/ldlp_core_test.sv */
// self-checking bench for the line diagnostic loopback and pattern block
`timescale 1ns/1ps
`default_nettype none
module ldlp_core_test;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ltp, ltn, rop, inh, aen, jal, pdn, irq, loop_back, lclk, tp, rp, rn, ptx, prx;
  logic host, ler, no_signal_alarm;
  logic [5:0] pc;
  int errors, checks, i;
  logic [17:0] cfg [13] = '{18'h20001, 18'h20041, 18'h20003, 18'h20004, 18'h2000c, 18'h20008,
    18'h20009, 18'h20045, 18'h00800, 18'h01000, 18'h02000, 18'h04000, 18'h12800};
  logic [5:0] flg [13] = '{6'h09, 6'h0d, 6'h02, 6'h10, 6'h10, 6'h20, 6'h29, 6'h1d, 6'h09,
    6'h02, 6'h10, 6'h20, 6'h1d};
  ////////////////////////////////////////////////////////////////////////////
  ldlp_core #(.LOSS_CYCLES(16), .MCLK_HALF(4)) uut (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in({1'b0, no_signal_alarm, 1'b0, ler, rn, rp, lclk, 1'b0, tp, lclk, pc, host}),
    .line_tx_pos(ltp), .line_tx_neg(ltn), .line_tx_clk(), .rx_out_pos(rop), .rx_out_neg(),
    .rx_out_clk(), .receiver_inhibit(inh), .analog_loop_en(aen), .ja_in_loop(jal),
    .pattern_detect_out_n(pdn), .bipolar_violation_out(), .pattern_irq(irq));
  ldlp_far_end far (.loop_back(loop_back), .line_pos(ltp), .line_neg(ltn), .link_clk(lclk),
    .tx_pos(tp), .rx_pos(rp), .rx_neg(rn), .last_tx(ptx), .last_rx(prx));
  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready, then an idle edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // ready is looked at mid-cycle so the edge that ends access is never raced
    @(negedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 50) begin
      errors++;
      results();
    end
  endtask
  // bounded wait on the pattern detect output
  task wait_pdn(input logic want, input int lim);
    int n;
    n = 0;
    while (pdn !== want && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      results();
    end
  endtask
  // compare looped paths on four bit periods, mid bit
  task bits(input logic [5:0] f);
    repeat (4) begin
      @(negedge lclk);
      #1;
      if (f[3]) chk(rop, ptx);
      if (f[4]) chk(ltp, prx);
      if (f[5]) chk(ltp | ltn, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // reset is held two edges; pins are steady from time zero so the flops are flushed
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {host, ler, no_signal_alarm, pc, loop_back, errors, checks} = {1'b1, 9'h0, 64'h0};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, ldlp_pkg::CTRL_OFF, 32'h0);
    chk(rd, {21'h0, ldlp_pkg::CTRL_RST});
    apb(1'b1, ldlp_pkg::CTRL_OFF, 32'hffffffff);
    apb(1'b0, ldlp_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h7ff);
    apb(1'b0, ldlp_pkg::STATUS_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // every loop and all-ones selection, by bits and by pins
    for (i = 0; i < 13; i++) begin
      host <= cfg[i][17];
      pc <= cfg[i][16:11];
      apb(1'b1, ldlp_pkg::CTRL_OFF, {21'h0, cfg[i][10:0]});
      repeat (3) @(negedge lclk);
      chk(inh, flg[i][0]);
      chk(aen, flg[i][1]);
      chk(jal, flg[i][2]);
      bits(flg[i]);
      @(posedge core_clk);
    end
    // pattern looped back through the far end until sync
    host <= 1'b1;
    pc <= 6'h00;
    loop_back <= 1'b1;
    apb(1'b1, ldlp_pkg::CTRL_OFF, 32'h20);
    wait_pdn(1'b0, 20000);
    apb(1'b0, ldlp_pkg::STATUS_OFF, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, ldlp_pkg::IRQ_CLR_OFF, 32'h1);
    apb(1'b0, ldlp_pkg::STATUS_OFF, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, ldlp_pkg::IRQ_CLR_OFF, 32'h0);
    // one inserted error gives three short pulses, sync kept
    ler <= 1'b1;
    wait_pdn(1'b1, 3000);
    ler <= 1'b0;
    wait_pdn(1'b0, 100);
    apb(1'b0, ldlp_pkg::STATUS_OFF, 32'h0);
    chk(rd[0], 1'b1);
    no_signal_alarm <= 1'b1;
    repeat (5) @(negedge lclk);
    chk(pdn, 1'b1);
    results();
  end
endmodule
`default_nettype wire

/* File: tb/ldlp_far_end.sv */
// far end model: framer clocks and rails for the line diagnostic block
`timescale 1ns/1ps
`default_nettype none
module ldlp_far_end (
  input wire logic loop_back, // feed line rails into receive rails
  input wire logic line_pos, // line positive rail from device
  input wire logic line_neg, // line negative rail from device
  output logic link_clk, // shared transmit and receive clock
  output logic tx_pos, // transmit data rail
  output logic rx_pos, // receive positive rail
  output logic rx_neg, // receive negative rail
  output logic last_tx, // transmit bit of the period just ended
  output logic last_rx // receive bit of the period just ended
);
  logic [3:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // free running line clock, 64 ns, unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    cnt_r = 4'h0;
    tx_pos = 1'b0;
    rx_pos = 1'b0;
    rx_neg = 1'b0;
    last_tx = 1'b0;
    last_rx = 1'b0;
    forever #32 link_clk = ~link_clk;
  end
  // rails move on the fall so they are settled at the sampling rise
  // line looped to receive, error-free otherwise
  always @(negedge link_clk) begin
    cnt_r <= cnt_r + 4'h1;
    last_tx <= tx_pos;
    last_rx <= rx_pos;
    tx_pos <= cnt_r[0] ^ cnt_r[2];
    rx_pos <= loop_back ? line_pos : cnt_r[1];
    rx_neg <= loop_back ? line_neg : 1'b0;
  end
endmodule
`default_nettype wire
